// ---- rtl/cfg_cmd_status.sv ----
/*
  Command and status registers of a bus function's configuration header, with the
  gating of master, memory and I/O activity and the sticky bus event flags.
  Assumes event inputs are one-cycle pulses from bus logic on the same clock,
  and that reset is the bus reset, synchronous to CLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_cmd_status
  import cfg_cmd_status_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Configuration access
  input wire logic CFG_RD_IN,
  input wire logic CFG_WR_IN,
  input wire logic [5:0] CFG_WORD_IN,
  input wire logic [3:0] CFG_BE_IN,
  input wire logic [31:0] CFG_WDATA_IN,
  output logic [31:0] CFG_RDATA_OUT,
  output logic CFG_ACK_OUT,
  // Requests from the bus logic, gated by the command bits
  input wire logic MASTER_REQ_IN,
  input wire logic MEM_HIT_IN,
  input wire logic IO_HIT_IN,
  input wire logic PERR_REQ_IN,
  output logic MASTER_REQ_OUT,
  output logic MEM_CLAIM_OUT,
  output logic IO_CLAIM_OUT,
  output logic PERR_DRIVE_OUT,
  // Command bit levels
  output logic MASTER_ENABLE_OUT,
  output logic MEMORY_RESPONSE_ENABLE_OUT,
  output logic IO_RESPONSE_ENABLE_OUT,
  output logic PARITY_ERROR_RESPONSE_OUT,
  // Bus event pulses
  input wire logic PARITY_ERR_IN,
  input wire logic SERR_DRIVEN_IN,
  input wire logic MASTER_ABORT_IN,
  input wire logic SPECIAL_CYCLE_IN,
  input wire logic TARGET_ABORT_RCV_IN,
  input wire logic TARGET_ABORT_SENT_IN,
  input wire logic PERR_DRIVEN_READ_IN,
  input wire logic PERR_SEEN_WRITE_IN,
  input wire logic ACTING_MASTER_IN,
  // Status word
  output logic [15:0] STATUS_OUT
);
  import cfg_cmd_status_pkg::*;

  logic [15:0] command_ff;
  logic [15:0] nxt_command;
  logic parity_error_detected_ff;
  logic system_error_signalled_ff;
  logic master_abort_received_ff;
  logic target_abort_received_ff;
  logic target_abort_signalled_ff;
  logic master_data_parity_error_ff;
  logic [1:0] select_timing_field;
  logic [15:0] status_word;
  logic [15:0] be_mask;
  logic cmd_hit;
  logic master_perr_event;
  logic [31:0] nxt_rdata;

  assign cmd_hit = (CFG_WORD_IN == CMD_STATUS_WORD);
  assign be_mask = {{8{CFG_BE_IN[1]}}, {8{CFG_BE_IN[0]}}};

  // Only the implemented command bits can be written; byte enables pick the lanes.
  always_comb begin
    nxt_command = command_ff;
    if (CFG_WR_IN && cmd_hit) begin
      nxt_command = (command_ff & ~(be_mask & CMD_WRITE_MASK)) | (CFG_WDATA_IN[15:0] & be_mask & CMD_WRITE_MASK);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      command_ff <= CMD_RESET;
    end else begin
      command_ff <= nxt_command;
    end
  end

  assign MASTER_ENABLE_OUT = command_ff[CMD_MASTER_BIT];
  assign MEMORY_RESPONSE_ENABLE_OUT = command_ff[CMD_MEM_BIT];
  assign IO_RESPONSE_ENABLE_OUT = command_ff[CMD_IO_BIT];
  assign PARITY_ERROR_RESPONSE_OUT = command_ff[CMD_PARITY_BIT];

  // The gates are combinational so a request never waits an extra cycle on a decode.
  assign MASTER_REQ_OUT = MASTER_REQ_IN && command_ff[CMD_MASTER_BIT];
  assign MEM_CLAIM_OUT = MEM_HIT_IN && command_ff[CMD_MEM_BIT];
  assign IO_CLAIM_OUT = IO_HIT_IN && command_ff[CMD_IO_BIT];
  assign PERR_DRIVE_OUT = PERR_REQ_IN && command_ff[CMD_PARITY_BIT];

  // The status flags have no software clear, so only bus reset returns them to zero.
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      parity_error_detected_ff <= 1'h0;
    end else if (PARITY_ERR_IN) begin
      parity_error_detected_ff <= 1'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      system_error_signalled_ff <= 1'h0;
    end else if (SERR_DRIVEN_IN) begin
      system_error_signalled_ff <= 1'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      master_abort_received_ff <= 1'h0;
    end else if (MASTER_ABORT_IN && !SPECIAL_CYCLE_IN) begin
      master_abort_received_ff <= 1'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      target_abort_received_ff <= 1'h0;
    end else if (TARGET_ABORT_RCV_IN) begin
      target_abort_received_ff <= 1'h1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      target_abort_signalled_ff <= 1'h0;
    end else if (TARGET_ABORT_SENT_IN) begin
      target_abort_signalled_ff <= 1'h1;
    end
  end

  assign master_perr_event = (PERR_DRIVEN_READ_IN || PERR_SEEN_WRITE_IN) && ACTING_MASTER_IN &&
                             command_ff[CMD_PARITY_BIT];

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      master_data_parity_error_ff <= 1'h0;
    end else if (master_perr_event) begin
      master_data_parity_error_ff <= 1'h1;
    end
  end

  assign select_timing_field = SEL_TIMING_RESET;

  // Reserved bits are tied to zero here and no write path reaches this word.
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_PARITY_DET_BIT] = parity_error_detected_ff;
    status_word[ST_SYS_ERR_BIT] = system_error_signalled_ff;
    status_word[ST_MABORT_RCV_BIT] = master_abort_received_ff;
    status_word[ST_TABORT_RCV_BIT] = target_abort_received_ff;
    status_word[ST_TABORT_SIG_BIT] = target_abort_signalled_ff;
    status_word[ST_SEL_TIMING_LSB +: 2] = select_timing_field;
    status_word[ST_MASTER_PERR_BIT] = master_data_parity_error_ff;
    status_word[ST_FAST_B2B_BIT] = FAST_B2B_VALUE;
    status_word[ST_HIGH_CLK_BIT] = HIGH_CLK_VALUE;
    status_word[ST_CAP_LIST_BIT] = CAP_LIST_VALUE;
  end

  assign STATUS_OUT = status_word;

  always_comb begin
    if (cmd_hit) begin
      nxt_rdata = {status_word, command_ff};
    end else begin
      nxt_rdata = UNMAPPED_READ;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CFG_RDATA_OUT <= 32'h0000_0000;
      CFG_ACK_OUT <= 1'h0;
    end else begin
      CFG_ACK_OUT <= CFG_RD_IN || CFG_WR_IN;
      if (CFG_RD_IN) begin
        CFG_RDATA_OUT <= nxt_rdata;
      end
    end
  end

  master_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !command_ff[CMD_MASTER_BIT] |-> !MASTER_REQ_OUT)
    else $error("Master request passed while master enable is low.");

  mem_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    MEM_CLAIM_OUT |-> MEM_HIT_IN && MEMORY_RESPONSE_ENABLE_OUT)
    else $error("Memory claim without enable.");

  io_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    IO_HIT_IN && !IO_RESPONSE_ENABLE_OUT |-> !IO_CLAIM_OUT)
    else $error("I/O claim without enable.");

  cmd_reset_a: assert property (@(posedge CLK_IN)
    RST_IN |=> !MASTER_ENABLE_OUT && !MEMORY_RESPONSE_ENABLE_OUT && !IO_RESPONSE_ENABLE_OUT &&
      !PARITY_ERROR_RESPONSE_OUT)
    else $error("Command bits not cleared by reset.");

  status_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_RD_IN && cmd_hit |=> CFG_ACK_OUT && CFG_RDATA_OUT[31:16] == $past(STATUS_OUT))
    else $error("Status read returned the wrong word.");

  status_ro_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_WR_IN && cmd_hit && !PARITY_ERR_IN && !SERR_DRIVEN_IN && !MASTER_ABORT_IN &&
      !TARGET_ABORT_RCV_IN && !TARGET_ABORT_SENT_IN && !master_perr_event |=> $stable(STATUS_OUT))
    else $error("Write changed the status word.");

  parity_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    PARITY_ERR_IN |=> STATUS_OUT[ST_PARITY_DET_BIT] [*2])
    else $error("Parity error flag not set and held.");

  serr_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_SYS_ERR_BIT]) |-> $past(SERR_DRIVEN_IN))
    else $error("System error flag rose without cause.");

  mabort_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_MABORT_RCV_BIT]) |-> $past(MASTER_ABORT_IN && !SPECIAL_CYCLE_IN))
    else $error("Master abort flag rose on a special cycle or without cause.");

  tabort_rcv_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    TARGET_ABORT_RCV_IN |=> STATUS_OUT[ST_TABORT_RCV_BIT])
    else $error("Received target abort flag not set.");

  tabort_sig_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    TARGET_ABORT_SENT_IN |=> STATUS_OUT[ST_TABORT_SIG_BIT])
    else $error("Signalled target abort flag not set.");

  fixed_bits_a: assert property (@(posedge CLK_IN)
    STATUS_OUT[10:9] == 2'h1 && !STATUS_OUT[7] && !STATUS_OUT[5] && STATUS_OUT[4] &&
      STATUS_OUT[6] == 1'h0 && STATUS_OUT[3:0] == 4'h0)
    else $error("Fixed status bits read wrong.");

  master_data_parity_error_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_MASTER_PERR_BIT]) |-> $past(ACTING_MASTER_IN && PARITY_ERROR_RESPONSE_OUT &&
      (PERR_DRIVEN_READ_IN || PERR_SEEN_WRITE_IN)))
    else $error("Master parity flag rose without all conditions.");

  perr_quiet_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !PARITY_ERROR_RESPONSE_OUT |-> !PERR_DRIVE_OUT)
    else $error("Parity error line driven with response disabled.");

  ack_pulse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_RD_IN || CFG_WR_IN |=> CFG_ACK_OUT)
    else $error("Access not acknowledged one cycle later.");

  ack_cause_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_ACK_OUT |-> $past(CFG_RD_IN || CFG_WR_IN))
    else $error("Acknowledge without an access.");

  rdata_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !CFG_RD_IN |=> $stable(CFG_RDATA_OUT))
    else $error("Read data changed without a read.");

  unmapped_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_RD_IN && !cmd_hit |=> CFG_RDATA_OUT == UNMAPPED_READ)
    else $error("Unmapped read returned data.");

  cmd_read_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_RD_IN && cmd_hit |=> CFG_RDATA_OUT[15:0] == $past(command_ff))
    else $error("Command read returned the wrong half word.");

  master_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_WR_IN && cmd_hit && CFG_BE_IN[0] |=> MASTER_ENABLE_OUT == $past(CFG_WDATA_IN[CMD_MASTER_BIT]))
    else $error("Master enable did not take the written value.");

  mem_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_WR_IN && cmd_hit && CFG_BE_IN[0] |=> MEMORY_RESPONSE_ENABLE_OUT == $past(CFG_WDATA_IN[CMD_MEM_BIT]))
    else $error("Memory enable did not take the written value.");

  io_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_WR_IN && cmd_hit && CFG_BE_IN[0] |=> IO_RESPONSE_ENABLE_OUT == $past(CFG_WDATA_IN[CMD_IO_BIT]))
    else $error("I/O enable did not take the written value.");

  cmd_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !(CFG_WR_IN && cmd_hit) |=> $stable(command_ff))
    else $error("Command changed without a write.");

  master_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    MASTER_REQ_IN && MASTER_ENABLE_OUT |-> MASTER_REQ_OUT)
    else $error("Enabled master request was blocked.");

  mem_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    MEM_HIT_IN && MEMORY_RESPONSE_ENABLE_OUT |-> MEM_CLAIM_OUT)
    else $error("Enabled memory hit was not claimed.");

  io_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    IO_HIT_IN && IO_RESPONSE_ENABLE_OUT |-> IO_CLAIM_OUT)
    else $error("Enabled I/O hit was not claimed.");

  perr_pass_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    PERR_REQ_IN && PARITY_ERROR_RESPONSE_OUT |-> PERR_DRIVE_OUT)
    else $error("Parity error line not driven with response enabled.");

  parity_cause_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_PARITY_DET_BIT]) |-> $past(PARITY_ERR_IN))
    else $error("Parity error flag rose without cause.");

  serr_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SERR_DRIVEN_IN |=> STATUS_OUT[ST_SYS_ERR_BIT])
    else $error("System error flag not set.");

  mabort_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    MASTER_ABORT_IN && !SPECIAL_CYCLE_IN |=> STATUS_OUT[ST_MABORT_RCV_BIT])
    else $error("Master abort flag not set.");

  tabort_rcv_cause_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_TABORT_RCV_BIT]) |-> $past(TARGET_ABORT_RCV_IN))
    else $error("Received target abort flag rose without cause.");

  tabort_sig_cause_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_TABORT_SIG_BIT]) |-> $past(TARGET_ABORT_SENT_IN))
    else $error("Signalled target abort flag rose without cause.");

  master_data_parity_error_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    master_perr_event |=> STATUS_OUT[ST_MASTER_PERR_BIT])
    else $error("Master parity flag not set.");

  flags_sticky_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ##1 (($past(STATUS_OUT) & ~STATUS_OUT) == 16'h0000))
    else $error("A status flag cleared outside reset.");

  cmd_write_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    CFG_WR_IN && cmd_hit ##1 MASTER_ENABLE_OUT ##1 MASTER_REQ_OUT);

  silent_parity_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    PARITY_ERR_IN && !PARITY_ERROR_RESPONSE_OUT ##1 STATUS_OUT[ST_PARITY_DET_BIT]);

  special_abort_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    MASTER_ABORT_IN && SPECIAL_CYCLE_IN);

  master_data_parity_error_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(STATUS_OUT[ST_MASTER_PERR_BIT]));

endmodule : cfg_cmd_status

`default_nettype wire

// ---- rtl/cfg_cmd_status_pkg.sv ----
/*
  Constants for the configuration command and status register block.
  Assumes configuration accesses address whole 32-bit words of configuration space.
*/
`default_nettype none

package cfg_cmd_status_pkg;

  // Word of configuration space holding command (low half) and status (high half).
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [5:0] CMD_STATUS_WORD = 6'h01;

  // Command bit positions.
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_PARITY_BIT = 6;
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0047;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // Status bit positions.
  localparam int ST_PARITY_DET_BIT = 15;
  localparam int ST_SYS_ERR_BIT = 14;
  localparam int ST_MABORT_RCV_BIT = 13;
  localparam int ST_TABORT_RCV_BIT = 12;
  localparam int ST_TABORT_SIG_BIT = 11;
  localparam int ST_SEL_TIMING_LSB = 9;
  localparam int ST_MASTER_PERR_BIT = 8;
  localparam int ST_FAST_B2B_BIT = 7;
  localparam int ST_HIGH_CLK_BIT = 5;
  localparam int ST_CAP_LIST_BIT = 4;

  // Select timing encodings; the slowest response used by this device is medium.
  localparam logic [1:0] SEL_TIMING_FAST = 2'h0;
  localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
  localparam logic [1:0] SEL_TIMING_SLOW = 2'h2;
  localparam logic [1:0] SEL_TIMING_RESET = SEL_TIMING_MEDIUM;

  // Fixed capability bits.
  localparam logic FAST_B2B_VALUE = 1'h0;
  localparam logic HIGH_CLK_VALUE = 1'h0;
  localparam logic CAP_LIST_VALUE = 1'h1;

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : cfg_cmd_status_pkg

`default_nettype wire

// ---- testbench/cfg_host_model.sv ----
/*
  Configuring host on the far side of the configuration port.
  Assumes the block answers every access with a one-cycle acknowledge one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
  // Clock
  input wire logic clk_in,
  // Configuration access toward the block
  output logic rd_out,
  output logic wr_out,
  output logic [5:0] word_out,
  output logic [3:0] be_out,
  output logic [31:0] wdata_out,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in
);
  initial begin
    rd_out = 1'h0;
    wr_out = 1'h0;
    word_out = 6'h3f;
    be_out = 4'h0;
    wdata_out = 32'h0;
  end

  // The strobe lasts one cycle; the answer is taken mid-cycle, where it has settled.
  // Idle lines then carry inverted values so stale data never looks valid.
  task automatic access(input logic rd, input logic wr, input logic [5:0] word, input logic [3:0] be,
      input logic [31:0] wdata, input int gap, output logic ok, output logic [31:0] rdata);
    @(negedge clk_in);
    rd_out <= rd;
    wr_out <= wr;
    word_out <= word;
    be_out <= be;
    wdata_out <= wdata;
    @(negedge clk_in);
    ok = ack_in;
    rdata = rdata_in;
    rd_out <= 1'h0;
    wr_out <= 1'h0;
    word_out <= ~word;
    be_out <= ~be;
    wdata_out <= ~wdata;
    repeat (gap) @(negedge clk_in);
  endtask : access
endmodule : cfg_host_model

`default_nettype wire

// ---- testbench/cfg_cmd_status_bench.sv ----
/*
  Self-checking bench for the command and status block, with random traffic.
  Assumes the host model in cfg_host_model and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_cmd_status_bench;
  import cfg_cmd_status_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rd, wr, ack, ok;
  logic [5:0] word;
  logic [3:0] be;
  logic [31:0] wdata, rdata, got;
  logic [31:0] rnd_data;
  logic [3:0] rnd_be;
  logic [3:0] req = 4'h0;
  logic [8:0] ev = 9'h0;
  logic [3:0] gate, lvl;
  logic [15:0] st, exp_cmd, exp_st;
  int errors = 0;
  int cmp_count = 0;
  int seed;

  always #4 clk = ~clk;

  cfg_host_model host (.clk_in(clk), .rd_out(rd), .wr_out(wr), .word_out(word), .be_out(be),
    .wdata_out(wdata), .ack_in(ack), .rdata_in(rdata));

  cfg_cmd_status DUT (.CLK_IN(clk), .RST_IN(rst), .CFG_RD_IN(rd), .CFG_WR_IN(wr), .CFG_WORD_IN(word),
    .CFG_BE_IN(be), .CFG_WDATA_IN(wdata), .CFG_RDATA_OUT(rdata), .CFG_ACK_OUT(ack),
    .MASTER_REQ_IN(req[2]), .MEM_HIT_IN(req[1]), .IO_HIT_IN(req[0]), .PERR_REQ_IN(req[3]),
    .MASTER_REQ_OUT(gate[2]), .MEM_CLAIM_OUT(gate[1]), .IO_CLAIM_OUT(gate[0]), .PERR_DRIVE_OUT(gate[3]),
    .MASTER_ENABLE_OUT(lvl[2]), .MEMORY_RESPONSE_ENABLE_OUT(lvl[1]), .IO_RESPONSE_ENABLE_OUT(lvl[0]),
    .PARITY_ERROR_RESPONSE_OUT(lvl[3]), .PARITY_ERR_IN(ev[0]), .SERR_DRIVEN_IN(ev[1]),
    .MASTER_ABORT_IN(ev[2]), .SPECIAL_CYCLE_IN(ev[3]), .TARGET_ABORT_RCV_IN(ev[4]),
    .TARGET_ABORT_SENT_IN(ev[5]), .PERR_DRIVEN_READ_IN(ev[6]), .PERR_SEEN_WRITE_IN(ev[7]),
    .ACTING_MASTER_IN(ev[8]), .STATUS_OUT(st));

  function automatic logic [15:0] nxt_cmd(logic [15:0] c, logic [31:0] d, logic [3:0] b);
    logic [15:0] m;
    m = {{8{b[1]}}, {8{b[0]}}} & CMD_WRITE_MASK;
    return (c & ~m) | (d[15:0] & m);
  endfunction : nxt_cmd

  // Sticky flags only ever gain bits, so one pass of events can be folded in at a time.
  function automatic logic [15:0] nxt_st(logic [15:0] s, logic [8:0] e, logic [15:0] c);
    s[15] |= e[0];
    s[14] |= e[1];
    s[13] |= e[2] & !e[3];
    s[12] |= e[4];
    s[11] |= e[5];
    s[8] |= e[8] & c[6] & (e[6] | e[7]);
    return s;
  endfunction : nxt_st

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic do_reset;
    @(negedge clk);
    rst = 1'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    exp_cmd = 16'h0000;
    exp_st = 16'h0210;
  endtask : do_reset

  task automatic cfg(input logic r, input logic w, input logic [5:0] wd, input logic [3:0] b,
      input logic [31:0] d);
    host.access(r, w, wd, b, d, $urandom % 3, ok, got);
    chk("ack", 32'h1, {31'h0, ok});
  endtask : cfg

  task automatic chk_gates;
    @(negedge clk);
    req = 4'($urandom);
    #1;
    chk("levels", {exp_cmd[6], exp_cmd[2:0]}, lvl);
    chk("gates", req & {exp_cmd[6], exp_cmd[2:0]}, gate);
  endtask : chk_gates

  task automatic run_events(input int n);
    repeat (n) begin
      @(negedge clk);
      ev = {9'($urandom)} & {1'h1, 1'h1, 1'h1, 6'($urandom)};
      exp_st = nxt_st(exp_st, ev, exp_cmd);
      @(negedge clk);
      ev[7:0] = 8'h0;
      chk("status", exp_st, st);
    end
  endtask : run_events

  initial begin
    #(8 * 20000);
    errors++;
    test_done;
  end

  initial begin
    seed = $urandom(16627);
    do_reset;
    cfg(1'h1, 1'h0, CMD_STATUS_WORD, 4'hf, 32'h0);
    chk("reset word", {16'h0210, 16'h0000}, got);
    chk_gates;
    for (int i = 0; i < 24; i++) begin
      rnd_data = (i == 0) ? 32'hffff_ffff : $urandom;
      rnd_be = (i == 0) ? 4'hf : 4'($urandom);
      cfg(1'h0, 1'h1, CMD_STATUS_WORD, rnd_be, rnd_data);
      exp_cmd = nxt_cmd(exp_cmd, rnd_data, rnd_be);
      cfg(1'h1, 1'h0, CMD_STATUS_WORD, 4'hf, 32'h0);
      chk("command word", {exp_st, exp_cmd}, got);
      chk_gates;
    end
    cfg(1'h0, 1'h1, 6'h02, 4'hf, 32'hffff_ffff);
    cfg(1'h1, 1'h0, 6'h02, 4'hf, 32'h0);
    chk("unmapped", UNMAPPED_READ, got);
    cfg(1'h1, 1'h1, CMD_STATUS_WORD, 4'h1, 32'h0000_0047);
    chk("read during write", {exp_st, exp_cmd}, got);
    exp_cmd = 16'h0047;
    chk_gates;
    do_reset;
    chk("second reset", {16'h0210, 16'h0000}, {st, 12'h0, lvl});
    run_events(30);
    do_reset;
    cfg(1'h0, 1'h1, CMD_STATUS_WORD, 4'h1, 32'h0000_0040);
    exp_cmd = 16'h0040;
    run_events(30);
    chk_gates;
    cfg(1'h1, 1'h0, CMD_STATUS_WORD, 4'hf, 32'h0);
    chk("event word", {exp_st, exp_cmd}, got);
    test_done;
  end
endmodule : cfg_cmd_status_bench

`default_nettype wire
